// ### eeprom_data_access_ctrl.sv
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - Address, data direct in bank 0; control not
// - Address is 6 bits, upper bits read zero
// - Data is 8-bit read/write, resets zero
// - Write starts only if write enable set
// - Write request stays high until write ends
// - Read starts only if read enable set
// - Read request clears with byte in data
// - Data holds fetched byte until next operation
// - Write length timed by tick source, sampled as a synchronous pulse
// - Write enable cleared at power-on
// - Write end sets both interrupt flags
// - Vector only with all enables, stack free
// - Service clears multi-function flag only
// - Power-down during a cycle makes it fail
// - Array holds 64 bytes, byte access only
// - Bank bit selects bank; direct hits bank 0
module eeprom_data_access_ctrl #(
  parameter int WRITE_TICKS = nvm_pkg::WRITE_TICKS
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire nvm_pkg::sfr_req_s SFR_REQ,
  input wire logic WRITE_TIMER_TICK,
  input wire logic POWER_DOWN,
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic NVM_IRQ_ENABLE,
  input wire logic MF_IRQ_ENABLE,
  input wire logic STACK_FULL,
  input wire logic IRQ_SERVICED,
  input wire logic NVM_IRQ_FLAG_CLEAR,
  output logic [7:0] SFR_RDATA,
  output logic SFR_RVALID,
  output logic BANK_SELECT,
  output logic NVM_BUSY,
  output logic ACCESS_FAILED,
  output logic NVM_IRQ_FLAG,
  output logic MF_IRQ_FLAG,
  output logic MF_IRQ_VECTOR
);

  // ********************************************************
  // Address decode
  // ********************************************************
  logic hit_addr;                            // Address register hit
  logic hit_data;                            // Data register hit
  logic hit_bank;                            // Bank selector hit
  logic hit_ctrl;                            // Control register hit

  // Control is bank 1 and indirect only; SFRs ignore bank
  assign hit_addr = SFR_REQ.addr == nvm_pkg::NVM_ADDRESS_OFS;
  assign hit_data = SFR_REQ.addr == nvm_pkg::NVM_DATA_OFS;
  assign hit_bank = SFR_REQ.addr == nvm_pkg::BANK_SELECTOR_OFS;
  assign hit_ctrl = SFR_REQ.indirect
      && BANK_SELECT == nvm_pkg::BANK_ONE
      && SFR_REQ.addr == nvm_pkg::NVM_CONTROL_OFS;

  // ********************************************************
  // Registers and cycle state
  // ********************************************************
  logic [nvm_pkg::ADDR_W-1:0] nvm_address;   // Byte address
  logic [nvm_pkg::DATA_W-1:0] nvm_data;      // Byte buffer
  logic [nvm_pkg::CTRL_W-1:0] nvm_control;   // Enables, requests
  nvm_pkg::nvm_state_e state;                // Cycle state
  logic [nvm_pkg::ADDR_W-1:0] lat_addr;      // Address of cycle
  logic [nvm_pkg::DATA_W-1:0] lat_data;      // Byte being written
  logic [nvm_pkg::ADDR_W-1:0] next_nvm_address;
  logic [nvm_pkg::DATA_W-1:0] next_nvm_data;
  logic [nvm_pkg::CTRL_W-1:0] next_nvm_control;
  nvm_pkg::nvm_state_e next_state;
  logic [nvm_pkg::ADDR_W-1:0] next_lat_addr;
  logic [nvm_pkg::DATA_W-1:0] next_lat_data;
  logic next_bank;
  logic next_busy;
  logic next_failed;

  // ********************************************************
  // Array side strobes
  // ********************************************************
  logic mem_rd;                              // Array read strobe
  logic mem_wr;                              // Array write strobe
  logic [nvm_pkg::DATA_W-1:0] mem_rdata;     // Fetched byte
  logic timer_start;                         // Write timer launch
  logic timer_done;                          // Write time elapsed
  logic write_end;                           // Write completes
  logic abort;                               // Power-down abort
  logic ctrl_wr;                             // Control write
  logic wr_req_new;                          // Write request ask
  logic rd_req_new;                          // Read request ask

  assign ctrl_wr = SFR_REQ.wr && hit_ctrl;
  assign wr_req_new = ctrl_wr && SFR_REQ.wdata[nvm_pkg::WRITE_REQ_BIT];
  assign rd_req_new = ctrl_wr && SFR_REQ.wdata[nvm_pkg::READ_REQ_BIT];
  assign abort = POWER_DOWN && state != nvm_pkg::S_IDLE;
  assign write_end = state == nvm_pkg::S_WRITE && timer_done && !abort;
  assign mem_rd = state == nvm_pkg::S_READ && !abort;
  assign mem_wr = write_end;

  // Next register values, cycle sequencing
  always_comb begin
    next_nvm_address = nvm_address;
    next_nvm_data = nvm_data;
    next_nvm_control = nvm_control;
    next_state = state;
    next_lat_addr = lat_addr;
    next_lat_data = lat_data;
    next_bank = BANK_SELECT;
    next_failed = 1'b0;
    timer_start = 1'b0;
    // Software writes to the plain registers
    if (SFR_REQ.wr && hit_addr) begin
      next_nvm_address = SFR_REQ.wdata[nvm_pkg::ADDR_W-1:0];
    end
    if (SFR_REQ.wr && hit_data) begin
      next_nvm_data = SFR_REQ.wdata;
    end
    if (SFR_REQ.wr && hit_bank) begin
      next_bank = SFR_REQ.wdata[0];
    end
    // Enables always writable; request bits guarded below
    if (ctrl_wr) begin
      next_nvm_control[nvm_pkg::WRITE_EN_BIT] =
          SFR_REQ.wdata[nvm_pkg::WRITE_EN_BIT];
      next_nvm_control[nvm_pkg::READ_EN_BIT] =
          SFR_REQ.wdata[nvm_pkg::READ_EN_BIT];
    end
    case (state)
      nvm_pkg::S_IDLE: begin
        // Enables are sampled before this write, so setting
        // enable and request together starts nothing
        if (wr_req_new && nvm_control[nvm_pkg::WRITE_EN_BIT]) begin
          next_nvm_control[nvm_pkg::WRITE_REQ_BIT] = 1'b1;
          next_lat_addr = nvm_address;
          next_lat_data = nvm_data;
          timer_start = 1'b1;
          next_state = nvm_pkg::S_WRITE;
        end else if (rd_req_new
            && nvm_control[nvm_pkg::READ_EN_BIT]) begin
          // Write wins if both asked, a misuse by software
          next_nvm_control[nvm_pkg::READ_REQ_BIT] = 1'b1;
          next_lat_addr = nvm_address;
          next_state = nvm_pkg::S_READ;
        end
      end
      nvm_pkg::S_READ: begin
        // Array read issued this cycle
        next_state = nvm_pkg::S_RLOAD;
      end
      nvm_pkg::S_RLOAD: begin
        // Fetched byte lands as the request drops
        next_nvm_data = mem_rdata;
        next_nvm_control[nvm_pkg::READ_REQ_BIT] = 1'b0;
        next_state = nvm_pkg::S_IDLE;
      end
      nvm_pkg::S_WRITE: begin
        // Request bit held high; software clears ignored
        if (timer_done) begin
          next_nvm_control[nvm_pkg::WRITE_REQ_BIT] = 1'b0;
          next_state = nvm_pkg::S_IDLE;
        end
      end
      default: begin
        next_state = nvm_pkg::S_IDLE;
      end
    endcase
    // Power-down kills the cycle; nothing reaches the array
    if (abort) begin
      next_nvm_control[nvm_pkg::WRITE_REQ_BIT] = 1'b0;
      next_nvm_control[nvm_pkg::READ_REQ_BIT] = 1'b0;
      next_state = nvm_pkg::S_IDLE;
      next_failed = 1'b1;
    end
    next_busy = next_state != nvm_pkg::S_IDLE;
  end

  // Register file and state; all reset to zero at power-on
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      nvm_address <= nvm_pkg::NVM_ADDRESS_RST;
      nvm_data <= nvm_pkg::NVM_DATA_RST;
      nvm_control <= nvm_pkg::NVM_CONTROL_RST;
      state <= nvm_pkg::S_IDLE;
      lat_addr <= '0;
      lat_data <= '0;
      BANK_SELECT <= nvm_pkg::BANK_SELECT_RST;
      NVM_BUSY <= 1'b0;
      ACCESS_FAILED <= 1'b0;
    end else begin
      nvm_address <= next_nvm_address;
      nvm_data <= next_nvm_data;
      nvm_control <= next_nvm_control;
      state <= next_state;
      lat_addr <= next_lat_addr;
      lat_data <= next_lat_data;
      BANK_SELECT <= next_bank;
      NVM_BUSY <= next_busy;
      ACCESS_FAILED <= next_failed;
    end
  end

  // ********************************************************
  // Read port
  // ********************************************************
  logic [7:0] next_rdata;
  logic next_rvalid;

  // Unimplemented bits read zero; unmapped gives no valid
  always_comb begin
    next_rdata = 8'h00;
    next_rvalid = 1'b0;
    if (SFR_REQ.rd) begin
      if (hit_ctrl) begin
        next_rdata = {4'h0, nvm_control};
        next_rvalid = 1'b1;
      end else if (hit_addr) begin
        next_rdata = {2'b00, nvm_address};
        next_rvalid = 1'b1;
      end else if (hit_data) begin
        next_rdata = nvm_data;
        next_rvalid = 1'b1;
      end else if (hit_bank) begin
        next_rdata = {7'h00, BANK_SELECT};
        next_rvalid = 1'b1;
      end
    end
  end

  // Register read answer
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      SFR_RDATA <= 8'h00;
      SFR_RVALID <= 1'b0;
    end else begin
      SFR_RDATA <= next_rdata;
      SFR_RVALID <= next_rvalid;
    end
  end

  // ********************************************************
  // Interrupt request flags
  // ********************************************************
  logic next_nvm_flag;
  logic next_mf_flag;
  logic next_vector;

  // Set wins over any clear arriving in the same cycle
  always_comb begin
    next_nvm_flag = NVM_IRQ_FLAG;
    next_mf_flag = MF_IRQ_FLAG;
    if (NVM_IRQ_FLAG_CLEAR) begin
      next_nvm_flag = 1'b0;
    end
    if (IRQ_SERVICED) begin
      next_mf_flag = 1'b0;
    end
    if (write_end) begin
      next_nvm_flag = 1'b1;
      next_mf_flag = 1'b1;
    end
    // Vector request needs every enable and stack room
    next_vector = next_mf_flag && next_nvm_flag && GLOBAL_IRQ_ENABLE
        && NVM_IRQ_ENABLE && MF_IRQ_ENABLE && !STACK_FULL;
  end

  // Register the flags
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      NVM_IRQ_FLAG <= 1'b0;
      MF_IRQ_FLAG <= 1'b0;
      MF_IRQ_VECTOR <= 1'b0;
    end else begin
      NVM_IRQ_FLAG <= next_nvm_flag;
      MF_IRQ_FLAG <= next_mf_flag;
      MF_IRQ_VECTOR <= next_vector;
    end
  end

  // ********************************************************
  // Array and write timer
  // ********************************************************
  // Array is never mapped into data memory, one byte a cycle
  nvm_array #(
    .ADDR_W(nvm_pkg::ADDR_W),
    .DATA_W(nvm_pkg::DATA_W),
    .DEPTH(nvm_pkg::DEPTH)
  ) u_array (
    .clk(CORE_CLK),
    .rd_en(mem_rd),
    .wr_en(mem_wr),
    .addr(lat_addr),
    .wdata(lat_data),
    .rdata(mem_rdata)
  );

  // Tick source is asynchronous in silicon; here it arrives
  // as a synchronous pulse, so write length varies with it
  nvm_write_timer #(
    .CNT_W(nvm_pkg::TICK_CNT_W),
    .TICKS(WRITE_TICKS)
  ) u_timer (
    .clk(CORE_CLK),
    .rst(RST),
    .start(timer_start),
    .abort(abort),
    .tick(WRITE_TIMER_TICK),
    .done(timer_done)
  );

endmodule : eeprom_data_access_ctrl
`default_nettype wire

// ### eeprom_data_access_ctrl_test.sv
`timescale 1ns/1ns
`default_nettype none

// ********************************************************
// Self-checking bench for the data memory controller
// ********************************************************
module eeprom_data_access_ctrl_test;
  localparam int WRITE_TP = 2; // Short write keeps the run brief
  localparam logic [7:0] A_OFS = nvm_pkg::NVM_ADDRESS_OFS;
  localparam logic [7:0] D_OFS = nvm_pkg::NVM_DATA_OFS;
  localparam logic [7:0] B_OFS = nvm_pkg::BANK_SELECTOR_OFS;
  localparam logic [7:0] C_OFS = nvm_pkg::NVM_CONTROL_OFS;
  logic core_clk;
  logic rst;
  logic tick;
  logic power_down;
  logic nvm_ie;
  logic mf_ie;
  logic stack_full;
  logic serviced;
  logic flag_clear;
  logic gie;
  nvm_pkg::sfr_req_s sfr_req;
  logic [7:0] sfr_rdata;
  logic sfr_rvalid;
  logic bank_select;
  logic busy;
  logic failed;
  logic nvm_flag;
  logic mf_flag;
  logic vector;
  int err_count;
  int cmp_count;
  int ticks; // Timer ticks seen while busy

  eeprom_data_access_ctrl #(.WRITE_TICKS(WRITE_TP))
    u_eeprom_data_access_ctrl (.CORE_CLK(core_clk), .RST(rst),
    .SFR_REQ(sfr_req), .WRITE_TIMER_TICK(tick), .POWER_DOWN(power_down),
    .GLOBAL_IRQ_ENABLE(gie), .NVM_IRQ_ENABLE(nvm_ie),
    .MF_IRQ_ENABLE(mf_ie), .STACK_FULL(stack_full),
    .IRQ_SERVICED(serviced), .NVM_IRQ_FLAG_CLEAR(flag_clear),
    .SFR_RDATA(sfr_rdata), .SFR_RVALID(sfr_rvalid),
    .BANK_SELECT(bank_select), .NVM_BUSY(busy), .ACCESS_FAILED(failed),
    .NVM_IRQ_FLAG(nvm_flag), .MF_IRQ_FLAG(mf_flag),
    .MF_IRQ_VECTOR(vector));

  nvm_cpu_model u_nvm_cpu_model (.clk(core_clk), .rdata(sfr_rdata),
    .rvalid(sfr_rvalid), .req(sfr_req), .gie(gie));

  // ********************************************************
  // Clock, timer ticks and tick counting
  // ********************************************************
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Tick every fourth cycle, free of bus traffic
  initial begin
    tick = 1'b0;
    forever begin
      repeat (3) @(posedge core_clk);
      #1 tick = 1'b1;
      @(posedge core_clk);
      #1 tick = 1'b0;
    end
  end
  always @(posedge core_clk) begin
    if (tick === 1'b1 && busy === 1'b1) ticks = ticks + 1;
  end

  // ********************************************************
  // Shared helpers
  // ********************************************************
  task automatic check(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic rd(input logic [7:0] a, output logic [7:0] q,
    output logic h);
    u_nvm_cpu_model.access(1'b0, 1'b0, a, 8'h00, q, h);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
    input logic ind);
    logic [7:0] q;
    logic h;
    u_nvm_cpu_model.access(1'b1, ind, a, d, q, h);
  endtask : wr

  // Polls one request bit until hardware clears it, bounded
  task automatic poll(input int b);
    logic [7:0] q;
    q = 8'hff;
    for (int i = 0; i < 100 && q[b] !== 1'b0; i++) begin
      u_nvm_cpu_model.ctrl_read(q);
    end
    check("request bit", 8'h00, {7'h00, q[b]});
  endtask : poll

  // One cycle pulse on an input, launched off the edge
  task automatic pulse(ref logic s);
    @(posedge core_clk);
    #1 s = 1'b1;
    @(posedge core_clk);
    #1 s = 1'b0;
  endtask : pulse

  // ********************************************************
  // Scenarios
  // ********************************************************
  task automatic t_regs();
    logic [7:0] q;
    logic h;
    rd(A_OFS, q, h); check("address reset", 8'h00, q);
    rd(D_OFS, q, h); check("data reset", 8'h00, q);
    rd(8'h77, q, h); check("unmapped", 8'h00, {q[7:1], h});
    wr(A_OFS, 8'hff, 1'b0);
    rd(A_OFS, q, h); check("address width", 8'h3f, q);
    wr(D_OFS, 8'ha5, 1'b0);
    rd(D_OFS, q, h); check("data rw", 8'ha5, q);
    wr(B_OFS, 8'hff, 1'b0);
    rd(B_OFS, q, h); check("bank width", 8'h01, q);
    u_nvm_cpu_model.ctrl_read(q); check("ctrl reset", 8'h00, q);
    wr(C_OFS, 8'h0a, 1'b0);
    u_nvm_cpu_model.ctrl_read(q); check("ctrl direct", 8'h00, q);
    rd(C_OFS, q, h); check("direct hit", 8'h00, {7'h00, h});
    u_nvm_cpu_model.ctrl_write(8'h01);
    u_nvm_cpu_model.ctrl_write(8'h04);
    u_nvm_cpu_model.ctrl_read(q); check("no enable", 8'h00, q);
    check("idle", 8'h00, {7'h00, busy});
    wr(B_OFS, 8'h00, 1'b0);
    wr(C_OFS, 8'h0a, 1'b1);
    wr(B_OFS, 8'h01, 1'b0);
    u_nvm_cpu_model.ctrl_read(q); check("bank zero", 8'h00, q);
  endtask : t_regs

  task automatic t_write();
    logic [7:0] q;
    ticks = 0;
    u_nvm_cpu_model.start_write(8'h3f, 8'h5a);
    check("busy", 8'h01, {7'h00, busy});
    u_nvm_cpu_model.ctrl_write(8'h0b);
    u_nvm_cpu_model.ctrl_read(q); check("ctrl busy", 8'h0e, q);
    poll(nvm_pkg::WRITE_REQ_BIT);
    check("tick floor", 8'h01, {7'h00, ticks >= WRITE_TP});
    check("tick ceil", 8'h01, {7'h00, ticks <= WRITE_TP + 1});
    u_nvm_cpu_model.ctrl_read(q); check("ctrl done", 8'h0a, q);
    check("flags", 8'h03, {6'h00, nvm_flag, mf_flag});
    check("stack full", 8'h00, {7'h00, vector});
    stack_full = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 check("vector", 8'h01, {7'h00, vector});
    pulse(serviced);
    check("after service", 8'h02, {6'h00, nvm_flag, mf_flag});
    pulse(flag_clear);
    check("after clear", 8'h00, {7'h00, nvm_flag});
  endtask : t_write

  task automatic t_read(input logic [7:0] exp);
    logic [7:0] q;
    logic h;
    u_nvm_cpu_model.start_read();
    u_nvm_cpu_model.ctrl_read(q); check("read busy", 8'h03, q);
    poll(nvm_pkg::READ_REQ_BIT);
    rd(D_OFS, q, h); check("fetched", exp, q);
    wr(A_OFS, 8'h00, 1'b0);
    rd(D_OFS, q, h); check("held", exp, q);
    check("no read irq", 8'h00, {7'h00, nvm_flag});
  endtask : t_read

  task automatic t_abort();
    logic [7:0] q;
    logic h;
    u_nvm_cpu_model.start_write(8'h3f, 8'h33);
    power_down = 1'b1;
    @(posedge core_clk);
    #1 power_down = 1'b0;
    check("fail pulse", 8'h01, {7'h00, failed});
    u_nvm_cpu_model.ctrl_read(q); check("ctrl abort", 8'h0a, q);
    rd(D_OFS, q, h); check("data abort", 8'h33, q);
    check("abort irq", 8'h00, {7'h00, nvm_flag});
  endtask : t_abort

  // ********************************************************
  // Verdict and run control
  // ********************************************************
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  // Watchdog: the tests need a few hundred cycles at most
  initial begin
    #100000;
    err_count++;
    complete_run();
  end

  initial begin
    rst = 1'b1;
    power_down = 1'b0;
    nvm_ie = 1'b1;
    mf_ie = 1'b1;
    stack_full = 1'b1;
    serviced = 1'b0;
    flag_clear = 1'b0;
    err_count = 0;
    cmp_count = 0;
    ticks = 0;
    repeat (16) @(posedge core_clk);
    #1 rst = 1'b0;
    t_regs();
    t_write();
    t_read(8'h5a);
    t_abort();
    t_read(8'h5a);
    complete_run();
  end
endmodule : eeprom_data_access_ctrl_test
`default_nettype wire

// ### nvm_array.sv
`timescale 1ns/1ns
`default_nettype none

module nvm_array #(
  parameter int ADDR_W = nvm_pkg::ADDR_W,
  parameter int DATA_W = nvm_pkg::DATA_W,
  parameter int DEPTH = nvm_pkg::DEPTH
) (
  input wire logic clk,
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  output logic [DATA_W-1:0] rdata
);

  // ********************************************************
  // Storage, one byte per access
  // ********************************************************
  logic [DATA_W-1:0] mem [DEPTH];            // Byte cells

  // Read data come out of a register
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[addr] <= wdata;
    end
    if (rd_en) begin
      rdata <= mem[addr];
    end
  end

endmodule : nvm_array
`default_nettype wire

// ### nvm_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none

// ********************************************************
// Program-side model issuing register accesses
// ********************************************************
module nvm_cpu_model (
  input wire logic clk,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  output var nvm_pkg::sfr_req_s req,
  output logic gie
);
  // Bus idle and interrupts enabled from time zero
  initial begin
    req = '0;
    gie = 1'b1;
  end

  // One access taken at one edge; released fields show inverted junk
  task automatic access(input logic w, input logic ind,
    input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q, output logic hit);
    @(posedge clk);
    #1;
    req = {w, !w, ind, a, d};
    @(posedge clk);
    #1;
    req = {2'b00, 1'b0, ~a, ~d};
    q = rdata;
    hit = rvalid;
  endtask : access

  // Control lives in bank one, reached only through the port
  task automatic ctrl_write(input logic [7:0] d);
    logic [7:0] q;
    logic h;
    access(1'b1, 1'b1, nvm_pkg::NVM_CONTROL_OFS, d, q, h);
  endtask : ctrl_write

  task automatic ctrl_read(output logic [7:0] q);
    logic h;
    access(1'b0, 1'b1, nvm_pkg::NVM_CONTROL_OFS, 8'h00, q, h);
  endtask : ctrl_read

  // Write start: interrupts masked, enable then request back to back
  task automatic start_write(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic h;
    access(1'b1, 1'b0, nvm_pkg::NVM_ADDRESS_OFS, a, q, h);
    access(1'b1, 1'b0, nvm_pkg::NVM_DATA_OFS, d, q, h);
    gie = 1'b0;
    ctrl_write(8'h0a);
    ctrl_write(8'h0e);
    gie = 1'b1;
  endtask : start_write

  // Read start: enable first, then the request on its own
  task automatic start_read();
    ctrl_write(8'h02);
    ctrl_write(8'h03);
  endtask : start_read
endmodule : nvm_cpu_model
`default_nettype wire

// ### nvm_ctrl_properties.sv
`timescale 1ns/1ns
`default_nettype none

// ********************************************************
// Port-level checks for the data memory controller
// ********************************************************
module nvm_ctrl_properties #(
  parameter int WRITE_TICKS = nvm_pkg::WRITE_TICKS
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire nvm_pkg::sfr_req_s SFR_REQ,
  input wire logic POWER_DOWN,
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic NVM_IRQ_ENABLE,
  input wire logic MF_IRQ_ENABLE,
  input wire logic STACK_FULL,
  input wire logic IRQ_SERVICED,
  input wire logic NVM_IRQ_FLAG_CLEAR,
  input wire logic BANK_SELECT,
  input wire logic NVM_BUSY,
  input wire logic ACCESS_FAILED,
  input wire logic NVM_IRQ_FLAG,
  input wire logic MF_IRQ_FLAG,
  input wire logic MF_IRQ_VECTOR
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  // Control write hit: indirect port, bank one, control offset
  logic ctrl_hit;
  assign ctrl_hit = SFR_REQ.wr && SFR_REQ.indirect && BANK_SELECT &&
                    SFR_REQ.addr == nvm_pkg::NVM_CONTROL_OFS;
  // All interrupt gates open
  logic irq_ready;
  assign irq_ready = GLOBAL_IRQ_ENABLE && NVM_IRQ_ENABLE &&
                     MF_IRQ_ENABLE && !STACK_FULL;

  // Read cycle: one more busy cycle, then idle
  sequence read_tail_s;
    NVM_BUSY ##1 !NVM_BUSY;
  endsequence
  // Abort: one-cycle fail pulse with the cycle dropped
  sequence abort_s;
    ACCESS_FAILED && !NVM_BUSY ##1 !ACCESS_FAILED;
  endsequence

  a_busy_from_ctrl: assert property ($rose(NVM_BUSY)
    |-> $past(ctrl_hit))
    else $error("busy rose without a control write");
  a_read_two_cycles: assert property ($rose(NVM_BUSY) && !POWER_DOWN &&
    !$past(SFR_REQ.wdata[nvm_pkg::WRITE_REQ_BIT]) |=> read_tail_s)
    else $error("read cycle length wrong");
  a_write_flags: assert property ($rose(NVM_IRQ_FLAG) |->
    $fell(NVM_BUSY) && MF_IRQ_FLAG)
    else $error("interrupt flags not set together at write end");
  a_mf_at_end: assert property ($rose(MF_IRQ_FLAG) |->
    $fell(NVM_BUSY) && NVM_IRQ_FLAG)
    else $error("multi-function flag rose outside write end");
  a_service_clears: assert property (IRQ_SERVICED |=>
    !MF_IRQ_FLAG || $fell(NVM_BUSY))
    else $error("service did not clear multi-function flag");
  a_service_keeps: assert property (IRQ_SERVICED && NVM_IRQ_FLAG &&
    !NVM_IRQ_FLAG_CLEAR |=> NVM_IRQ_FLAG)
    else $error("service cleared the memory flag");
  a_vector_gate: assert property (MF_IRQ_VECTOR |-> $past(irq_ready))
    else $error("vector raised with a gate closed");
  a_vector_raise: assert property (irq_ready && MF_IRQ_FLAG &&
    NVM_IRQ_FLAG && !IRQ_SERVICED && !NVM_IRQ_FLAG_CLEAR
    |=> MF_IRQ_VECTOR)
    else $error("vector missing with all gates open");
  a_abort_pd: assert property (NVM_BUSY && POWER_DOWN |=> abort_s)
    else $error("power-down did not abort the cycle");
  a_abort_no_irq: assert property (ACCESS_FAILED |->
    !$rose(NVM_IRQ_FLAG) && !$rose(MF_IRQ_FLAG))
    else $error("aborted cycle raised an interrupt");
  a_bank_write: assert property (SFR_REQ.wr &&
    SFR_REQ.addr == nvm_pkg::BANK_SELECTOR_OFS
    |=> BANK_SELECT == $past(SFR_REQ.wdata[0]))
    else $error("bank selector not written");
endmodule : nvm_ctrl_properties

bind eeprom_data_access_ctrl nvm_ctrl_properties #(
  .WRITE_TICKS(WRITE_TICKS)
) u_nvm_ctrl_properties (.CORE_CLK, .RST, .SFR_REQ, .POWER_DOWN,
  .GLOBAL_IRQ_ENABLE, .NVM_IRQ_ENABLE, .MF_IRQ_ENABLE, .STACK_FULL,
  .IRQ_SERVICED, .NVM_IRQ_FLAG_CLEAR, .BANK_SELECT, .NVM_BUSY,
  .ACCESS_FAILED, .NVM_IRQ_FLAG, .MF_IRQ_FLAG, .MF_IRQ_VECTOR);
`default_nettype wire

// ### nvm_pkg.sv
`default_nettype none
package nvm_pkg;

  // ********************************************************
  // Array geometry
  // ********************************************************
  localparam int ADDR_W = 6;                 // Byte address width
  localparam int DATA_W = 8;                 // Byte width
  localparam int DEPTH = 64;                 // Bytes in the array

  // ********************************************************
  // Register map
  // ********************************************************
  localparam logic [7:0] NVM_ADDRESS_OFS = 8'h1e;   // Bank 0 SFR
  localparam logic [7:0] NVM_DATA_OFS = 8'h1f;      // Bank 0 SFR
  localparam logic [7:0] BANK_SELECTOR_OFS = 8'h04; // Common SFR
  localparam logic [7:0] NVM_CONTROL_OFS = 8'h40;   // Bank 1 only
  localparam logic BANK_ONE = 1'b1;                 // Control bank

  // ********************************************************
  // Control register fields
  // ********************************************************
  localparam int READ_REQ_BIT = 0;           // Read request
  localparam int READ_EN_BIT = 1;            // read_enable_bit
  localparam int WRITE_REQ_BIT = 2;          // Write request
  localparam int WRITE_EN_BIT = 3;           // write_enable_bit
  localparam int CTRL_W = 4;                 // Implemented bits

  // ********************************************************
  // Reset values
  // ********************************************************
  localparam logic [ADDR_W-1:0] NVM_ADDRESS_RST = 6'h00;
  localparam logic [DATA_W-1:0] NVM_DATA_RST = 8'h00;
  localparam logic [CTRL_W-1:0] NVM_CONTROL_RST = 4'h0;
  localparam logic BANK_SELECT_RST = 1'b0;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int WRITE_TICKS = 16;           // Timer ticks per write
  localparam int TICK_CNT_W = 8;             // Tick counter width

  // ********************************************************
  // Types
  // ********************************************************
  typedef struct packed {
    logic wr;                                // Write strobe
    logic rd;                                // Read strobe
    logic indirect;                          // Via indirect port
    logic [7:0] addr;                        // Data memory address
    logic [7:0] wdata;                       // Write byte
  } sfr_req_s;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,                          // No cycle
    S_READ = 2'b01,                          // Array read issued
    S_RLOAD = 2'b10,                         // Load fetched byte
    S_WRITE = 2'b11                          // Timed write running
  } nvm_state_e;

endpackage : nvm_pkg
`default_nettype wire

// ### nvm_write_timer.sv
`timescale 1ns/1ns
`default_nettype none

module nvm_write_timer #(
  parameter int CNT_W = nvm_pkg::TICK_CNT_W,
  parameter int TICKS = nvm_pkg::WRITE_TICKS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic abort,
  input wire logic tick,
  output logic done
);

  // ********************************************************
  // Tick counter
  // ********************************************************
  localparam logic [CNT_W-1:0] LAST = CNT_W'(TICKS - 1);
  logic [CNT_W-1:0] cnt;                     // Ticks seen
  logic run;                                 // Timing a write
  logic [CNT_W-1:0] next_cnt;
  logic next_run;
  logic next_done;

  // Length follows the tick source, not the system clock
  always_comb begin
    next_cnt = cnt;
    next_run = run;
    next_done = 1'b0;
    if (abort) begin
      next_run = 1'b0;
    end else if (start) begin
      next_run = 1'b1;
      next_cnt = '0;
    end else if (run && tick) begin
      if (cnt == LAST) begin
        next_run = 1'b0;
        next_done = 1'b1;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  // Register the counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      run <= 1'b0;
      done <= 1'b0;
    end else begin
      cnt <= next_cnt;
      run <= next_run;
      done <= next_done;
    end
  end

endmodule : nvm_write_timer
`default_nettype wire
